// ===== design/irq_mask_pkg.sv
package irq_mask_pkg;

   // ----------------------------------------
   // special-function addresses, visible on every page
   // ----------------------------------------
   localparam logic [7:0] addr_mask_one = 8'he6;
   localparam logic [7:0] addr_mask_two = 8'he7;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0] reset_mask_one = 8'h00;
   localparam logic [7:0] reset_mask_two = 8'h00;

   // ----------------------------------------
   // field positions, first mask register
   // ----------------------------------------
   localparam int pos_counter_array_irq_en = 3;
   localparam int pos_adc_a_window_irq_en = 2;
   localparam int pos_smbus_irq_en = 1;
   localparam int pos_spi_irq_en = 0;

   // ----------------------------------------
   // field positions, second mask register
   // ----------------------------------------
   localparam int pos_two_reserved = 7;
   localparam int pos_uart_b_irq_en = 6;
   localparam int pos_can_irq_en = 5;
   localparam int pos_adc_c_done_irq_en = 4;
   localparam int pos_adc_c_window_irq_en = 3;
   localparam int pos_timer_four_irq_en = 2;
   localparam int pos_adc_a_done_irq_en = 1;
   localparam int pos_timer_three_irq_en = 0;

   // pending flags of the gated sources, one bit each
   typedef struct packed {
      logic counter_array;
      logic adc_a_window;
      logic smbus;
      logic spi;
      logic uart_b;
      logic can;
      logic adc_c_done;
      logic adc_c_window;
      logic timer_four;
      logic adc_a_done;
      logic timer_three;
   } irq_src_type;

   // special-function register access from the core
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } sfr_req_type;

endpackage : irq_mask_pkg

// ===== design/extended_interrupt_enable_regs.sv
`timescale 1ns/10ps
`default_nettype none

module extended_interrupt_enable_regs
   import irq_mask_pkg::*;
#(
   parameter bit has_adc_c = 1'b1
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire sfr_req_type sfr_req,
   output logic sfr_hit,
   output logic [7:0] sfr_rdata,
   input wire irq_src_type src_flag,
   output var irq_src_type irq_req,
   output logic [7:0] interrupt_mask_one,
   output logic [7:0] interrupt_mask_two
);

   // ----------------------------------------
   // widths and decoding
   // ----------------------------------------
   localparam int mask_width = 8;
   localparam int field_count_one = 4;
   localparam int field_count_two = 8;

   // one-hot image of a field position; an out-of-range position yields nothing
   function automatic logic [7:0] field_bit(input int pos);
      logic [7:0] image;
      image = 8'h00;
      if (pos >= 0 && pos < mask_width) begin
         image[pos] = 1'h1;
      end
      return image;
   endfunction : field_bit

   // address decode is shared by write, read and hit, so it is defined once
   function automatic logic hits_mask_one(input logic [7:0] addr);
      return addr == addr_mask_one;
   endfunction : hits_mask_one

   function automatic logic hits_mask_two(input logic [7:0] addr);
      return addr == addr_mask_two;
   endfunction : hits_mask_two

   // a request passes only while flag and enable are both high; the flag itself is never written
   function automatic logic gate_request(input logic flag, input logic enable);
      return flag & enable;
   endfunction : gate_request

   // ----------------------------------------
   // elaboration checks
   // ----------------------------------------
   localparam logic [7:0] used_one = field_bit(pos_counter_array_irq_en) | field_bit(pos_adc_a_window_irq_en)
      | field_bit(pos_smbus_irq_en) | field_bit(pos_spi_irq_en);
   localparam logic [7:0] used_two = field_bit(pos_two_reserved) | field_bit(pos_uart_b_irq_en)
      | field_bit(pos_can_irq_en) | field_bit(pos_adc_c_done_irq_en)
      | field_bit(pos_adc_c_window_irq_en) | field_bit(pos_timer_four_irq_en)
      | field_bit(pos_adc_a_done_irq_en) | field_bit(pos_timer_three_irq_en);

   // a field outside the byte or two fields on one bit would leave a source ungated
   if ($countones(used_one) != field_count_one) begin : g_bad_fields_one
      $error("mask one field positions overlap or leave the byte");
   end
   if ($countones(used_two) != field_count_two) begin : g_bad_fields_two
      $error("mask two field positions overlap or leave the byte");
   end
   if (addr_mask_one == addr_mask_two) begin : g_bad_addr
      $error("both mask registers decode at one address");
   end

   // ----------------------------------------
   // access decode
   // ----------------------------------------
   // the page register is not an input: both addresses decode on every page
   logic wr_mask_one;
   logic wr_mask_two;
   logic rd_strobe;

   assign wr_mask_one = sfr_req.wr && hits_mask_one(sfr_req.addr);
   assign wr_mask_two = sfr_req.wr && hits_mask_two(sfr_req.addr);
   assign rd_strobe = sfr_req.rd;
   assign sfr_hit = hits_mask_one(sfr_req.addr) || hits_mask_two(sfr_req.addr);

   // ----------------------------------------
   // mask one
   // ----------------------------------------
   // bits 7 to 4 are plain storage here: they read back but steer nothing
   logic [7:0] mask_one_reg;
   logic [7:0] mask_one_next;

   always_comb begin
      mask_one_next = mask_one_reg;
      if (wr_mask_one) begin
         mask_one_next = sfr_req.wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mask_one_reg <= reset_mask_one;
      end else begin
         mask_one_reg <= mask_one_next;
      end
   end

   // ----------------------------------------
   // mask two
   // ----------------------------------------
   // bit 7 is stored and read back, but no source hangs on it
   logic [7:0] mask_two_reg;
   logic [7:0] mask_two_next;

   always_comb begin
      mask_two_next = mask_two_reg;
      if (wr_mask_two) begin
         mask_two_next = sfr_req.wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mask_two_reg <= reset_mask_two;
      end else begin
         mask_two_reg <= mask_two_next;
      end
   end

   // ----------------------------------------
   // read data
   // ----------------------------------------
   // registered read data: valid the edge after the strobe, held until the next read
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;

   always_comb begin
      rdata_next = rdata_reg;
      if (rd_strobe) begin
         if (hits_mask_one(sfr_req.addr)) begin
            rdata_next = mask_one_reg;
         end else if (hits_mask_two(sfr_req.addr)) begin
            rdata_next = mask_two_reg;
         end else begin
            rdata_next = 8'h00;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign sfr_rdata = rdata_reg;
   assign interrupt_mask_one = mask_one_reg;
   assign interrupt_mask_two = mask_two_reg;

   // ----------------------------------------
   // enable fields
   // ----------------------------------------
   logic counter_array_irq_en;
   logic adc_a_window_irq_en;
   logic smbus_irq_en;
   logic spi_irq_en;
   logic uart_b_irq_en;
   logic can_irq_en;
   logic adc_c_done_irq_en;
   logic adc_c_window_irq_en;
   logic timer_four_irq_en;
   logic adc_a_done_irq_en;
   logic timer_three_irq_en;

   assign counter_array_irq_en = mask_one_reg[pos_counter_array_irq_en];
   assign adc_a_window_irq_en = mask_one_reg[pos_adc_a_window_irq_en];
   assign smbus_irq_en = mask_one_reg[pos_smbus_irq_en];
   assign spi_irq_en = mask_one_reg[pos_spi_irq_en];
   // without the third converter its enables still store, but they gate nothing
   assign adc_c_done_irq_en = has_adc_c && mask_two_reg[pos_adc_c_done_irq_en];
   assign adc_c_window_irq_en = has_adc_c && mask_two_reg[pos_adc_c_window_irq_en];
   assign uart_b_irq_en = mask_two_reg[pos_uart_b_irq_en];
   assign can_irq_en = mask_two_reg[pos_can_irq_en];
   assign timer_four_irq_en = mask_two_reg[pos_timer_four_irq_en];
   assign adc_a_done_irq_en = mask_two_reg[pos_adc_a_done_irq_en];
   assign timer_three_irq_en = mask_two_reg[pos_timer_three_irq_en];

   // ----------------------------------------
   // request gating, purely combinational so flags are never altered
   // ----------------------------------------
   always_comb begin
      irq_req.counter_array = gate_request(src_flag.counter_array, counter_array_irq_en);
      irq_req.adc_a_window = gate_request(src_flag.adc_a_window, adc_a_window_irq_en);
      irq_req.smbus = gate_request(src_flag.smbus, smbus_irq_en);
      irq_req.spi = gate_request(src_flag.spi, spi_irq_en);
      irq_req.uart_b = gate_request(src_flag.uart_b, uart_b_irq_en);
      irq_req.can = gate_request(src_flag.can, can_irq_en);
      irq_req.adc_c_done = gate_request(src_flag.adc_c_done, adc_c_done_irq_en);
      irq_req.adc_c_window = gate_request(src_flag.adc_c_window, adc_c_window_irq_en);
      irq_req.timer_four = gate_request(src_flag.timer_four, timer_four_irq_en);
      irq_req.adc_a_done = gate_request(src_flag.adc_a_done, adc_a_done_irq_en);
      irq_req.timer_three = gate_request(src_flag.timer_three, timer_three_irq_en);
   end

endmodule : extended_interrupt_enable_regs

`default_nettype wire

// ===== bench/irq_mask_sva.sv
`timescale 1ns/10ps
`default_nettype none
module irq_mask_sva
   import irq_mask_pkg::*;
#(
   parameter bit has_adc_c = 1'b1
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire sfr_req_type sfr_req,
   input wire logic sfr_hit,
   input wire logic [7:0] sfr_rdata,
   input wire irq_src_type src_flag,
   input wire irq_src_type irq_req,
   input wire logic [7:0] interrupt_mask_one,
   input wire logic [7:0] interrupt_mask_two
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence w1; sfr_req.wr && sfr_req.addr == addr_mask_one; endsequence
   sequence w2; sfr_req.wr && sfr_req.addr == addr_mask_two; endsequence
   AST_W1: assert property (w1 |=> interrupt_mask_one == $past(sfr_req.wdata)) else $error("w1");
   AST_W2: assert property (w2 |=> interrupt_mask_two == $past(sfr_req.wdata)) else $error("w2");
   AST_KEEP: assert property (!(sfr_req.wr && sfr_hit) |=>
      $stable({interrupt_mask_one, interrupt_mask_two})) else $error("keep");
   AST_RD: assert property (sfr_req.rd |=> sfr_rdata == (!$past(sfr_hit) ? 8'h00 :
      $past(sfr_req.addr[0]) ? $past(interrupt_mask_two) : $past(interrupt_mask_one))) else $error("rd");
   AST_G1: assert property (irq_req[10:7] == (src_flag[10:7] & interrupt_mask_one[3:0]))
      else $error("g1");
   AST_G2: assert property (irq_req[6:5] == (src_flag[6:5] & interrupt_mask_two[6:5])) else $error("g2");
   AST_G3: assert property (irq_req[4:3] == (src_flag[4:3] & interrupt_mask_two[4:3] & {2{has_adc_c}}))
      else $error("g3");
   AST_G4: assert property (irq_req[2:0] == (src_flag[2:0] & interrupt_mask_two[2:0])) else $error("g4");
endmodule : irq_mask_sva
bind extended_interrupt_enable_regs irq_mask_sva #(.has_adc_c(has_adc_c)) u_sva (.clk(clk), .rst_b(rst_b),
   .sfr_req(sfr_req), .sfr_hit(sfr_hit), .sfr_rdata(sfr_rdata), .src_flag(src_flag), .irq_req(irq_req),
   .interrupt_mask_one(interrupt_mask_one), .interrupt_mask_two(interrupt_mask_two));
`default_nettype wire

// ===== bench/irq_src_model.sv
`timescale 1ns/10ps
`default_nettype none
module irq_src_model
   import irq_mask_pkg::*;
(
   input wire logic [10:0] pend,
   output var irq_src_type src_flag
);
   // flags stay up until their source clears them; a mask write never does
   assign src_flag = irq_src_type'(pend);
endmodule : irq_src_model
`default_nettype wire

// ===== bench/extended_interrupt_enable_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module extended_interrupt_enable_regs_tb import irq_mask_pkg::*;;
   logic clk = 1'h0;
   logic rst_b = 1'h0;
   sfr_req_type sfr_req = '0;
   logic [10:0] pend = 11'h7ff;
   logic [7:0] sfr_rdata, m1, m2;
   logic sfr_hit;
   logic [7:0] p1 [2] = '{8'h0a, 8'hf5};
   logic [7:0] p2 [2] = '{8'haa, 8'h55};
   logic [10:0] pv [3] = '{11'h7ff, 11'h5a5, 11'h2da};
   irq_src_type src_flag, irq_req, irq_req_bare;
   int fail_count = 0;
   int checked = 0;
   always #5 clk = ~clk;
   irq_src_model u_src (.pend(pend), .src_flag(src_flag));
   extended_interrupt_enable_regs u_dut (.clk(clk), .rst_b(rst_b), .sfr_req(sfr_req), .sfr_hit(sfr_hit),
      .sfr_rdata(sfr_rdata), .src_flag(src_flag), .irq_req(irq_req), .interrupt_mask_one(m1),
      .interrupt_mask_two(m2));
   // variant without the third converter, driven by the same accesses
   extended_interrupt_enable_regs #(.has_adc_c(1'b0)) u_dut_bare (.clk(clk), .rst_b(rst_b), .sfr_req(sfr_req),
      .sfr_hit(), .sfr_rdata(), .src_flag(src_flag), .irq_req(irq_req_bare), .interrupt_mask_one(),
      .interrupt_mask_two());
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w, input logic hit);
      @(posedge clk);
      #1 sfr_req = '{a, d, w, !w};
      #1 chk({15'h0, sfr_hit}, {15'h0, hit});
      @(posedge clk);
      #1 sfr_req = '0;
   endtask : acc
   task automatic finish_test;
      if (fail_count == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test
   initial begin
      #5000;
      fail_count++;
      finish_test;
   end
   initial begin
      repeat (3) @(posedge clk);
      #1 rst_b = 1'h1;
      chk({m1, m2}, 16'h0000);
      chk({5'h0, irq_req}, 16'h0000);
      for (int k = 0; k < 2; k++) begin
         acc(8'he6, p1[k], 1'h1, 1'h1);
         acc(8'he7, p2[k], 1'h1, 1'h1);
         acc(8'he5, 8'h00, 1'h1, 1'h0);
         chk({m1, m2}, {p1[k], p2[k]});
         for (int j = 0; j < 3; j++) begin
            pend = pv[j];
            #1 chk({5'h0, irq_req}, {5'h0, pv[j] & {p1[k][3:0], p2[k][6:0]}});
            chk({5'h0, irq_req_bare}, {5'h0, pv[j] & {p1[k][3:0], p2[k][6:5], 2'h0, p2[k][2:0]}});
         end
         acc(8'he6, 8'h00, 1'h0, 1'h1);
         chk({8'h0, sfr_rdata}, {8'h0, p1[k]});
         acc(8'he7, 8'h00, 1'h0, 1'h1);
         chk({8'h0, sfr_rdata}, {8'h0, p2[k]});
         acc(8'he5, 8'h00, 1'h0, 1'h0);
         chk({8'h0, sfr_rdata}, 16'h0000);
      end
      // a reset in mid-run must clear masks and read data whatever they held
      acc(8'he7, 8'h00, 1'h0, 1'h1);
      @(posedge clk);
      #1 rst_b = 1'h0;
      #1 chk({m1, m2}, 16'h0000);
      chk({8'h0, sfr_rdata}, 16'h0000);
      chk({5'h0, irq_req}, 16'h0000);
      @(posedge clk);
      #1 rst_b = 1'h1;
      acc(8'he7, 8'h40, 1'h1, 1'h1);
      acc(8'he7, 8'h00, 1'h0, 1'h1);
      chk({8'h0, sfr_rdata}, 16'h0040);
      finish_test;
   end
endmodule : extended_interrupt_enable_regs_tb
`default_nettype wire
